// ---- hdl/pad_pkg.sv ----
package pad_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] PORT0_ALIAS_OFS = 8'hf8;
    localparam logic [7:0] PORT1_ALIAS_OFS = 8'hf9;
    localparam logic [7:0] PORT2_ALIAS_OFS = 8'hfa;
    localparam logic [6:0] ALIAS_RESET = 7'h00;
    localparam int ALIAS_FIELD_LSB = 1;
    localparam int NUM_ALIAS_PORTS = 3;

    // Primary target address of the device; value is arbitrary.
    localparam logic [6:0] PRIMARY_ADDR = 7'h30;

    // ************************************************************
    // Transfer constants
    // ************************************************************
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] LINE_IDLE = 2'h3;

    // Target state machine, one-hot.
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_AACK = 9'h004,
        ST_OFS = 9'h008,
        ST_OACK = 9'h010,
        ST_WDAT = 9'h020,
        ST_WACK = 9'h040,
        ST_RDAT = 9'h080,
        ST_RACK = 9'h100
    } pad_state_t;

endpackage

// ---- hdl/pad_line_sync.sv ----
// ************************************************************
// Two-stage synchroniser with edge detection for one bus line
// ************************************************************
module pad_line_sync (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic line_in,
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);

    logic [1:0] sync_q;
    logic last_q;

    // The first stage feeds only the second; the bus idles high.
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            sync_q <= pad_pkg::LINE_IDLE;
            last_q <= 1'b1;
        end else begin
            sync_q <= {sync_q[0], line_in};
            last_q <= sync_q[1];
        end
    end

    // Edges are found between the second stage and its delayed copy.
    assign level_out = sync_q[1];
    assign rise_out = sync_q[1] & ~last_q;
    assign fall_out = ~sync_q[1] & last_q;

endmodule

// ---- hdl/pad_alias_decoder.sv ----
// Behaviour
// (R1) Each port has a 7-bit alias in bits 7:1 matched against target addresses.
// (R2) An alias field of zero disables that port's decoder entirely.
// (R3) Alias access reaches that port's registers regardless of page selection.
// (R4) Alias access also reads and writes all shared registers.
// (R5) Alias is extra; the primary, paged path keeps working.
// (R6) Each port alias is separate; port 1 alias register at 0xf9.
// (R7) Port 2 alias at 0xfa; all alias registers reset to zero.
// (R8) Bit 0 reads zero, ignores writes; primary address stays active.
module pad_alias_decoder (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire logic [1:0] page_sel_in,
    input wire logic [7:0] reg_rdata_in,
    output logic reg_rd_out,
    output logic reg_wr_out,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic [1:0] reg_port_out,
    output logic [2:0] alias_enabled_out
);

    // ************************************************************
    // Functions
    // ************************************************************

    // A decoder hits only when its field is nonzero and equal.
    function automatic logic alias_hit(input logic [6:0] addr,
                                       input logic [6:0] field);
        alias_hit = (field != pad_pkg::ALIAS_RESET) && (addr == field);
    endfunction

    // True for offsets held inside this block.
    function automatic logic is_local(input logic [7:0] ofs);
        is_local = (ofs == pad_pkg::PORT0_ALIAS_OFS) ||
                   (ofs == pad_pkg::PORT1_ALIAS_OFS) ||
                   (ofs == pad_pkg::PORT2_ALIAS_OFS);
    endfunction

    // ************************************************************
    // Signals
    // ************************************************************
    logic scl_s, scl_rise, scl_fall;
    logic sda_s, sda_rise, sda_fall;
    logic start_w, stop_w;
    pad_pkg::pad_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] ofs_q;
    logic [7:0] tx_q;
    logic rw_q, nack_q, drive_q;
    logic [1:0] port_q;
    logic wr_q;
    logic [7:0] wdata_q;
    logic [6:0] port0_alias_field_q;
    logic [6:0] port1_alias_field_q;
    logic [6:0] port2_alias_field_q;
    logic [2:0] hit_w;
    logic prim_w;
    logic byte_done_w;
    logic rd_load_w;
    logic [7:0] rd_byte_w;

    pad_line_sync u_scl (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .line_in(scl_in),
        .level_out(scl_s),
        .rise_out(scl_rise),
        .fall_out(scl_fall)
    );

    pad_line_sync u_sda (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .line_in(sda_in),
        .level_out(sda_s),
        .rise_out(sda_rise),
        .fall_out(sda_fall)
    );

    // Start and stop are data edges while the clock line is high.
    assign start_w = sda_fall & scl_s;
    assign stop_w = sda_rise & scl_s;

    // ************************************************************
    // Address decode
    // ************************************************************

    // Each port compares on its own; the primary is always live.
    assign hit_w[0] = alias_hit(shift_q[7:1], port0_alias_field_q); // R1 R2
    assign hit_w[1] = alias_hit(shift_q[7:1], port1_alias_field_q); // R6
    assign hit_w[2] = alias_hit(shift_q[7:1], port2_alias_field_q); // R2
    assign prim_w = (shift_q[7:1] == pad_pkg::PRIMARY_ADDR); // R5 R8
    assign byte_done_w = scl_fall && (cnt_q == pad_pkg::BITS_PER_BYTE);

    // A read byte is fetched when entering a data phase of a read.
    assign rd_load_w = scl_fall && (((state_q == pad_pkg::ST_AACK) && rw_q)
                       || ((state_q == pad_pkg::ST_RACK) && !nack_q));

    // Local alias registers read with bit 0 as zero; others go outward.
    always_comb begin
        rd_byte_w = reg_rdata_in; // R4
        if (ofs_q == pad_pkg::PORT0_ALIAS_OFS) begin
            rd_byte_w = {port0_alias_field_q, 1'b0}; // R8
        end else if (ofs_q == pad_pkg::PORT1_ALIAS_OFS) begin
            rd_byte_w = {port1_alias_field_q, 1'b0}; // R8
        end else if (ofs_q == pad_pkg::PORT2_ALIAS_OFS) begin
            rd_byte_w = {port2_alias_field_q, 1'b0}; // R8
        end
    end

    // ************************************************************
    // Target state machine
    // ************************************************************

    // Sequences address, offset, write and read bytes with acknowledge.
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            state_q <= pad_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ofs_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            drive_q <= 1'b0;
            port_q <= 2'h0;
        end else if (stop_w) begin
            state_q <= pad_pkg::ST_IDLE;
            drive_q <= 1'b0;
        end else if (start_w) begin
            state_q <= pad_pkg::ST_ADDR;
            cnt_q <= 4'h0;
            drive_q <= 1'b0;
        end else begin
            if (scl_rise) begin
                shift_q <= {shift_q[6:0], sda_s};
                cnt_q <= cnt_q + 4'h1;
                if (state_q == pad_pkg::ST_RACK) begin
                    nack_q <= sda_s;
                end
            end
            case (state_q)
                pad_pkg::ST_ADDR: begin
                    if (byte_done_w) begin
                        rw_q <= shift_q[0];
                        if (hit_w[0]) begin
                            port_q <= 2'h0; // R3
                        end else if (hit_w[1]) begin
                            port_q <= 2'h1; // R3
                        end else if (hit_w[2]) begin
                            port_q <= 2'h2; // R3
                        end else begin
                            port_q <= page_sel_in; // R5
                        end
                        if (prim_w || (hit_w != 3'h0)) begin
                            drive_q <= 1'b1;
                            state_q <= pad_pkg::ST_AACK;
                        end else begin
                            state_q <= pad_pkg::ST_IDLE;
                        end
                    end
                end
                pad_pkg::ST_AACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            tx_q <= {rd_byte_w[6:0], 1'b0};
                            drive_q <= ~rd_byte_w[7];
                            ofs_q <= ofs_q + 8'h01;
                            state_q <= pad_pkg::ST_RDAT;
                        end else begin
                            drive_q <= 1'b0;
                            state_q <= pad_pkg::ST_OFS;
                        end
                    end
                end
                pad_pkg::ST_OFS: begin
                    if (byte_done_w) begin
                        ofs_q <= shift_q;
                        drive_q <= 1'b1;
                        state_q <= pad_pkg::ST_OACK;
                    end
                end
                pad_pkg::ST_OACK,
                pad_pkg::ST_WACK: begin
                    if (scl_fall) begin
                        if (state_q == pad_pkg::ST_WACK) begin
                            ofs_q <= ofs_q + 8'h01;
                        end
                        cnt_q <= 4'h0;
                        drive_q <= 1'b0;
                        state_q <= pad_pkg::ST_WDAT;
                    end
                end
                pad_pkg::ST_WDAT: begin
                    if (byte_done_w) begin
                        drive_q <= 1'b1;
                        state_q <= pad_pkg::ST_WACK;
                    end
                end
                pad_pkg::ST_RDAT: begin
                    if (scl_fall) begin
                        if (cnt_q == pad_pkg::BITS_PER_BYTE) begin
                            drive_q <= 1'b0;
                            cnt_q <= 4'h0;
                            state_q <= pad_pkg::ST_RACK;
                        end else begin
                            drive_q <= ~tx_q[7];
                            tx_q <= {tx_q[6:0], 1'b0};
                        end
                    end
                end
                pad_pkg::ST_RACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (nack_q) begin
                            state_q <= pad_pkg::ST_IDLE;
                        end else begin
                            tx_q <= {rd_byte_w[6:0], 1'b0};
                            drive_q <= ~rd_byte_w[7];
                            ofs_q <= ofs_q + 8'h01;
                            state_q <= pad_pkg::ST_RDAT;
                        end
                    end
                end
                default: begin
                    drive_q <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Register access
    // ************************************************************

    // Completed write bytes to non-local offsets become a one-cycle outward strobe.
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            wr_q <= 1'b0;
            wdata_q <= 8'h00;
        end else begin
            wr_q <= (state_q == pad_pkg::ST_WDAT) && byte_done_w &&
                    !is_local(ofs_q); // R4
            if ((state_q == pad_pkg::ST_WDAT) && byte_done_w) begin
                wdata_q <= shift_q;
            end
        end
    end

    // Alias registers keep bits 7:1 only; bit 0 is never stored.
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            port0_alias_field_q <= pad_pkg::ALIAS_RESET; // R7
            port1_alias_field_q <= pad_pkg::ALIAS_RESET; // R7
            port2_alias_field_q <= pad_pkg::ALIAS_RESET; // R7
        end else if ((state_q == pad_pkg::ST_WDAT) && byte_done_w) begin
            if (ofs_q == pad_pkg::PORT0_ALIAS_OFS) begin
                port0_alias_field_q <= shift_q[7:1]; // R1
            end
            if (ofs_q == pad_pkg::PORT1_ALIAS_OFS) begin
                port1_alias_field_q <= shift_q[7:1]; // R6
            end
            if (ofs_q == pad_pkg::PORT2_ALIAS_OFS) begin
                port2_alias_field_q <= shift_q[7:1]; // R7
            end
        end
    end

    // Open-drain data line: enable is low while pulling low.
    assign sda_out = 1'b0;
    assign sda_oe_n_out = ~drive_q;
    assign reg_rd_out = rd_load_w && !is_local(ofs_q);
    assign reg_wr_out = wr_q;
    assign reg_addr_out = ofs_q;
    assign reg_wdata_out = wdata_q;
    assign reg_port_out = port_q;
    assign alias_enabled_out = {port2_alias_field_q != 7'h00,
                                port1_alias_field_q != 7'h00,
                                port0_alias_field_q != 7'h00};

    // ************************************************************
    // Checks
    // ************************************************************
    chk_zero_alias_off: assert property (@(posedge clock_in) // R2
        disable iff (!rstn_in)
        (state_q == pad_pkg::ST_ADDR && byte_done_w && !stop_w &&
         !start_w && !prim_w && shift_q[7:1] == 7'h00)
        |=> (state_q == pad_pkg::ST_IDLE) && sda_oe_n_out)
        else $error("Address zero answered through a cleared alias.");

    chk_alias_reset_zero: assert property (@(posedge clock_in) // R7
        !rstn_in |=> (alias_enabled_out == 3'h0))
        else $error("Alias registers not zero after reset.");

    chk_alias_route_port: assert property (@(posedge clock_in) // R3
        disable iff (!rstn_in)
        (state_q == pad_pkg::ST_ADDR && byte_done_w && !stop_w &&
         !start_w && hit_w[1] && !hit_w[0])
        |=> (port_q == 2'h1) && (state_q == pad_pkg::ST_AACK))
        else $error("Alias access not routed to its port.");

    chk_paged_path: assert property (@(posedge clock_in) // R5
        disable iff (!rstn_in)
        (state_q == pad_pkg::ST_ADDR && byte_done_w && !stop_w &&
         !start_w && hit_w == 3'h0 && prim_w)
        |=> (port_q == $past(page_sel_in)) && !sda_oe_n_out)
        else $error("Primary access ignored page selection.");

    chk_shared_write: assert property (@(posedge clock_in) // R4
        disable iff (!rstn_in)
        (state_q == pad_pkg::ST_WDAT && byte_done_w && !stop_w &&
         !start_w && !is_local(ofs_q))
        |=> reg_wr_out && (reg_wdata_out == $past(shift_q)) ##1 !reg_wr_out)
        else $error("Shared register write strobe wrong.");

    chk_alias_write: assert property (@(posedge clock_in) // R6
        disable iff (!rstn_in)
        (state_q == pad_pkg::ST_WDAT && byte_done_w && !stop_w &&
         !start_w && ofs_q == pad_pkg::PORT1_ALIAS_OFS)
        |=> (port1_alias_field_q == $past(shift_q[7:1])) &&
            $stable(port0_alias_field_q) && $stable(port2_alias_field_q))
        else $error("Port 1 alias write not applied alone.");

    chk_reserved_zero: assert property (@(posedge clock_in) // R8
        disable iff (!rstn_in)
        (rd_load_w && is_local(ofs_q)) |-> (rd_byte_w[0] == 1'b0))
        else $error("Reserved alias bit read as one.");

    chk_alias_decode: assert property (@(posedge clock_in) // R1
        disable iff (!rstn_in)
        (state_q == pad_pkg::ST_ADDR && byte_done_w && !stop_w &&
         !start_w && port0_alias_field_q != 7'h00 &&
         shift_q[7:1] == port0_alias_field_q)
        |=> (port_q == 2'h0) && (state_q == pad_pkg::ST_AACK))
        else $error("Enabled port 0 alias did not match.");

endmodule

// ---- test/pad_i2c_host.sv ----
// ************************************************************
// Control bus host: drives SCL and pulls SDA low, 400 ns bit time
// ************************************************************
module pad_i2c_host (
    output logic scl_out,
    output logic sda_low_out,
    input wire logic sda_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // SCL starts driven high and SDA released, so the pull-up holds it high.
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    // One bit sent: data changes in the middle of the low phase.
    // Lines change just after a clock edge, so no synchroniser races them.
    task automatic bit_out(input logic b);
        #100 sda_low_out <= !b;
        #100 scl_out <= 1'b1;
        #200 scl_out <= 1'b0;
    endtask

    // One bit taken late in the high phase, where the device holds it.
    task automatic bit_in(output logic b);
        #100 sda_low_out <= 1'b0;
        #100 scl_out <= 1'b1;
        #190 b = sda_in;
        #10 scl_out <= 1'b0;
    endtask

    // A start, also usable as a repeated start while SCL is low.
    task automatic start();
        #100 sda_low_out <= 1'b0;
        #100 scl_out <= 1'b1;
        #200 sda_low_out <= 1'b1;
        #200 scl_out <= 1'b0;
    endtask

    // A stop, then bus idle with both lines released.
    task automatic stop();
        #100 sda_low_out <= 1'b1;
        #100 scl_out <= 1'b1;
        #200 sda_low_out <= 1'b0;
        #400;
    endtask

    // A byte sent most significant bit first, then the acknowledge read.
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(b);
        ack = !b;
    endtask

    // A byte read; the last byte of a read is answered with a release.
    task automatic rbyte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(last);
    endtask
endmodule

// ---- test/pad_alias_decoder_bench.sv ----
module pad_alias_decoder_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock_in, rstn_in, scl, host_low, sda_wire, sda_o, sda_oe_n;
    logic rd_w, wr_w, ack;
    logic [1:0] page_sel, port_w, wr_port_seen;
    logic [2:0] alias_en;
    logic [6:0] al;
    logic [7:0] rdata, addr_w, wdata_w, wr_addr_seen, wr_data_seen, d;
    logic [7:0] wr_count, cnt0, rd_count;
    logic [7:0] mem [0:1023];
    int miscompares = 0;
    int total_checks = 0;

    // ************************************************************
    // Clock, open-drain wire and outward register file
    // ************************************************************
    // The clock toggles every half period of 25 ns.
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    // SDA is low when either party pulls it, else the pull-up wins.
    assign sda_wire = host_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);
    // Each port has its own page, so read data shows the routed port.
    assign rdata = mem[{port_w, addr_w}];

    // Outward writes land in the page of the reported port.
    always @(posedge clock_in) begin
        if (wr_w) begin
            mem[{port_w, addr_w}] <= wdata_w;
            wr_addr_seen <= addr_w;
            wr_data_seen <= wdata_w;
            wr_port_seen <= port_w;
            wr_count <= wr_count + 8'h01;
        end
    end

    // Outward reads are counted to check the read strobe.
    always @(posedge clock_in) begin
        if (rd_w) begin
            rd_count <= rd_count + 8'h01;
        end
    end

    pad_alias_decoder dut (
        .clock_in(clock_in), .rstn_in(rstn_in), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
        .page_sel_in(page_sel), .reg_rdata_in(rdata),
        .reg_rd_out(rd_w), .reg_wr_out(wr_w), .reg_addr_out(addr_w),
        .reg_wdata_out(wdata_w), .reg_port_out(port_w),
        .alias_enabled_out(alias_en)
    );

    pad_i2c_host u_host (
        .scl_out(scl),
        .sda_low_out(host_low),
        .sda_in(sda_wire)
    );

    // ************************************************************
    // Access tasks and checking
    // ************************************************************
    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // Writes one register: address, offset, data, then stop.
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                             input logic [7:0] data, output logic ok);
        logic a2, a3;
        a2 = 1'b1;
        a3 = 1'b1;
        u_host.start();
        u_host.wbyte({dev, 1'b0}, ok);
        if (ok) begin
            u_host.wbyte(ofs, a2);
            u_host.wbyte(data, a3);
        end
        u_host.stop();
        ok = ok & a2 & a3;
    endtask

    // Reads one register through a repeated start.
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
                            output logic [7:0] data, output logic ok);
        logic a2, a3;
        a2 = 1'b1;
        a3 = 1'b1;
        data = 8'h00;
        u_host.start();
        u_host.wbyte({dev, 1'b0}, ok);
        if (ok) begin
            u_host.wbyte(ofs, a2);
            u_host.start();
            u_host.wbyte({dev, 1'b1}, a3);
            u_host.rbyte(1'b1, data);
        end
        u_host.stop();
        ok = ok & a2 & a3;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // The whole run needs about 5900 cycles; stop a hang well after.
    initial begin
        repeat (60000) @(posedge clock_in);
        miscompares++;
        $display("watchdog expired at %0t", $time);
        stop_test();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        rstn_in = 1'b0;
        page_sel = 2'h0;
        wr_count = 8'h00;
        rd_count = 8'h00;
        for (int i = 0; i < 1024; i++) begin
            mem[i] = i[7:0] ^ 8'ha5;
        end
        repeat (2) @(posedge clock_in);
        rstn_in <= 1'b1;
        repeat (8) @(posedge clock_in);
        // Alias registers come out of reset cleared and disabled.
        check({5'h0, alias_en}, 8'h00);
        cnt0 = rd_count;
        for (int k = 0; k < 3; k++) begin
            read_reg(pad_pkg::PRIMARY_ADDR,
                     pad_pkg::PORT0_ALIAS_OFS + k[7:0], d, ack);
            check({7'h0, ack}, 8'h01);
            check(d, 8'h00);
        end
        check(rd_count, cnt0);
        $display("test reset values done");
        // Cleared decoders answer no address, not even zero.
        cnt0 = wr_count;
        write_reg(7'h00, 8'h10, 8'h11, ack);
        check({7'h0, ack}, 8'h00);
        write_reg(7'h41, 8'h10, 8'h11, ack);
        check({7'h0, ack}, 8'h00);
        check(wr_count, cnt0);
        $display("test disabled decoders done");
        // Program each alias with bit 0 set; bit 0 must read back zero.
        for (int k = 0; k < 3; k++) begin
            al = 7'h41 + k[6:0];
            write_reg(pad_pkg::PRIMARY_ADDR,
                      pad_pkg::PORT0_ALIAS_OFS + k[7:0], {al, 1'b1}, ack);
            read_reg(pad_pkg::PRIMARY_ADDR,
                     pad_pkg::PORT0_ALIAS_OFS + k[7:0], d, ack);
            check(d, {al, 1'b0});
        end
        check({5'h0, alias_en}, 8'h07);
        $display("test alias programming done");
        // Alias access reaches its own port whatever page is selected.
        @(posedge clock_in);
        page_sel <= 2'h3;
        for (int k = 0; k < 3; k++) begin
            al = 7'h41 + k[6:0];
            write_reg(al, 8'h10, 8'h5a + k[7:0], ack);
            check({7'h0, ack}, 8'h01);
            check({6'h0, wr_port_seen}, {6'h0, k[1:0]});
            check(wr_addr_seen, 8'h10);
            check(wr_data_seen, 8'h5a + k[7:0]);
            cnt0 = rd_count;
            read_reg(al, 8'h10, d, ack);
            check(d, 8'h5a + k[7:0]);
            check(rd_count, cnt0 + 8'h01);
        end
        $display("test alias routing done");
        // The primary address still follows the page selection.
        @(posedge clock_in);
        page_sel <= 2'h1;
        write_reg(pad_pkg::PRIMARY_ADDR, 8'h20, 8'h33, ack);
        check({7'h0, ack}, 8'h01);
        check({6'h0, wr_port_seen}, 8'h01);
        read_reg(pad_pkg::PRIMARY_ADDR, 8'h20, d, ack);
        check(d, 8'h33);
        $display("test primary path done");
        // Port 0 alias clears port 1 alias; port 2 keeps working.
        write_reg(7'h41, pad_pkg::PORT1_ALIAS_OFS, 8'h00, ack);
        check({7'h0, ack}, 8'h01);
        check({5'h0, alias_en}, 8'h05);
        write_reg(7'h42, 8'h10, 8'h77, ack);
        check({7'h0, ack}, 8'h00);
        read_reg(7'h43, pad_pkg::PORT1_ALIAS_OFS, d, ack);
        check({7'h0, ack}, 8'h01);
        check(d, 8'h00);
        $display("test alias disable done");
        stop_test();
    end
endmodule
